//--- hdl/rop_cfg.svh
// register map, field positions, reset values and selector codes of the raster-op stage
// assumes: included by bare name from the design file and the testbench
`ifndef ROP_CFG_SVH
`define ROP_CFG_SVH
`define OFF_CTRL 12'h000
`define OFF_TARGET 12'h004
`define OFF_OBJECT 12'h008
`define OFF_ALLOC 12'h00c
`define OFF_STATUS 12'h010
`define CTRL_INDEX_BIT 0
`define CTRL_COLOR_BIT 1
`define CTRL_BLEND_BIT 2
`define CTRL_MSAA_BIT 3
`define CTRL_FLOAT_BIT 4
`define CTRL_ROP_LSB 8
`define CTRL_ROP_MSB 11
`define ALLOC_MASK_MSB 3
`define ALLOC_XCNT_LSB 8
`define ALLOC_XCNT_MSB 12
`define ST_BAD_OP 0
`define ST_BAD_VAL 1
`define ST_BAD_ENUM 2
`define ALLOC_MASK_RST 4'hf
`define ALLOC_XCNT_RST 5'h00
`define ROP_RST 4'h3
`define TGT_NONE 8'h00
`define TGT_FL 8'h01
`define TGT_FR 8'h02
`define TGT_BL 8'h03
`define TGT_BR 8'h04
`define TGT_FRONT 8'h05
`define TGT_BACK 8'h06
`define TGT_LEFT 8'h07
`define TGT_RIGHT 8'h08
`define TGT_FAB 8'h09
`define TGT_EXTRA0 8'h10
`define TGT_ATTACH0 8'h20
`define TGT_BASE_MASK 8'hf0
`define TGT_N_MASK 8'h0f
`endif

//--- hdl/rop_pkg.sv
// types shared by the raster-op stage
// assumes: rop_cfg.svh on the include path
package rop_pkg;
  // order is the encoding: code k is the k-th function, so the code is its own truth table
  typedef enum logic [3:0] {
    ROP_ZERO, ROP_AND, ROP_AND_NOT_D, ROP_COPY, ROP_NOT_S_AND, ROP_KEEP, ROP_XOR, ROP_OR,
    ROP_NOR, ROP_XNOR, ROP_NOT_D, ROP_OR_NOT_D, ROP_NOT_S, ROP_NOT_S_OR, ROP_NAND, ROP_ONES
  } rop_fn_t;
  typedef logic [7:0] target_code_t;
endpackage

//--- hdl/fragment_rop.sv
// fragment raster-op stage: logic function, per-sample update, resolve, target selection
// assumes: APB master on pclk; upstream delivers stored sample values and test results with
// each fragment; downstream accepts one write bundle per wr_valid/wr_ready handshake
//
// Overview of operation
// - combine fragment value with stored value by selected function, write result back
// - separate enables for index and colour logic functions
// - colour logic function enabled means blending is bypassed
// - float destination: no logic function, blending still suppressed
// - each fragment colour is combined with its own target buffer
// - function applied per index buffer and per colour component
// - selector resets to copy, both enables cleared
// - sixteen bitwise functions of source and destination
// - target none leaves multisample and colour buffers unchanged
// - multisample on with sample buffer: operations run per sample
// - a failed test ends only that sample
// - operations run on a sample only when its coverage bit is one
// - multisample off: full coverage, centre test, stencil written everywhere
// - centre pass writes all depth and colour samples, fail writes none
// - samples merged into one value written to the selected buffers
// - merge is a plain per-component average
// - single-target command sets colour zero, others become none
// - default selectors name zero, one, two or four buffers
// - extra buffer n is base plus n, below extra buffer count
// - object selector is attach point base plus n, initially point zero
// - default framebuffer, no allocated buffer named: bad operation error
// - object bound with default code: bad operation; index at or above limit: bad value
`timescale 1ns/100ps
`default_nettype none
`include "rop_cfg.svh"
module fragment_rop #(
  parameter int COLORS = 2,
  parameter int SAMPLES = 4,
  parameter int CW = 8,
  parameter int SAMPLE_BUFFERS = 1,
  parameter int ATTACH_LIMIT = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic frag_valid,
  output logic frag_ready,
  input wire logic frag_index_mode,
  input wire logic [15:0] frag_x,
  input wire logic [15:0] frag_y,
  input wire logic [COLORS-1:0][3:0][CW-1:0] frag_src,
  input wire logic [COLORS-1:0][SAMPLES-1:0][3:0][CW-1:0] frag_dst,
  input wire logic [SAMPLES-1:0] frag_coverage,
  input wire logic [SAMPLES-1:0] frag_test_pass,
  input wire logic frag_center_pass,
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [15:0] wr_x,
  output logic [15:0] wr_y,
  output logic [COLORS-1:0] wr_color_en,
  output rop_pkg::target_code_t [COLORS-1:0] wr_target,
  output logic [COLORS-1:0][SAMPLES-1:0][3:0][CW-1:0] wr_sample,
  output logic [COLORS-1:0][SAMPLES-1:0] wr_sample_mask,
  output logic [SAMPLES-1:0] wr_depth_mask,
  output logic [SAMPLES-1:0] wr_stencil_mask,
  output logic [COLORS-1:0][3:0][CW-1:0] wr_resolved,
  output logic blend_active
);
  import rop_pkg::*;

  localparam int SW = CW + $clog2(SAMPLES);

  logic index_en_reg, color_en_reg, blend_en_reg, msaa_en_reg, dest_float_reg;
  rop_fn_t rop_reg;
  logic [7:0] object_id_reg;
  logic [3:0] alloc_mask_reg;
  logic [4:0] extra_count_reg;
  logic [2:0] err_reg;
  target_code_t [COLORS-1:0] target_reg;

  // ---------------- APB slave: zero wait states ----------------
  logic acc, wr_acc, hit;
  assign acc = psel & penable;
  assign wr_acc = acc & pwrite;
  assign pready = 1'b1;
  assign hit = paddr == `OFF_CTRL || paddr == `OFF_TARGET || paddr == `OFF_OBJECT ||
               paddr == `OFF_ALLOC || paddr == `OFF_STATUS;
  assign pslverr = acc & ~hit;

  always_comb begin
    prdata = 32'h0000_0000;
    case (paddr)
      `OFF_CTRL: begin
        prdata[`CTRL_INDEX_BIT] = index_en_reg;
        prdata[`CTRL_COLOR_BIT] = color_en_reg;
        prdata[`CTRL_BLEND_BIT] = blend_en_reg;
        prdata[`CTRL_MSAA_BIT] = msaa_en_reg;
        prdata[`CTRL_FLOAT_BIT] = dest_float_reg;
        prdata[`CTRL_ROP_MSB:`CTRL_ROP_LSB] = rop_reg;
      end
      `OFF_TARGET: prdata[7:0] = target_reg[0];
      `OFF_OBJECT: prdata[7:0] = object_id_reg;
      `OFF_ALLOC: begin
        prdata[`ALLOC_MASK_MSB:0] = alloc_mask_reg;
        prdata[`ALLOC_XCNT_MSB:`ALLOC_XCNT_LSB] = extra_count_reg;
      end
      `OFF_STATUS: prdata[2:0] = err_reg;
      default: prdata = 32'h0000_0000;
    endcase
  end

  // legacy_rop_enable is the same bit as index_rop_enable, so one register holds both
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      index_en_reg <= 1'b0;
      color_en_reg <= 1'b0;
      blend_en_reg <= 1'b0;
      msaa_en_reg <= 1'b0;
      dest_float_reg <= 1'b0;
      rop_reg <= rop_fn_t'(`ROP_RST);
    end else if (wr_acc && paddr == `OFF_CTRL) begin
      index_en_reg <= pwdata[`CTRL_INDEX_BIT];
      color_en_reg <= pwdata[`CTRL_COLOR_BIT];
      blend_en_reg <= pwdata[`CTRL_BLEND_BIT];
      msaa_en_reg <= pwdata[`CTRL_MSAA_BIT];
      dest_float_reg <= pwdata[`CTRL_FLOAT_BIT];
      rop_reg <= rop_fn_t'(pwdata[`CTRL_ROP_MSB:`CTRL_ROP_LSB]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      alloc_mask_reg <= `ALLOC_MASK_RST;
      extra_count_reg <= `ALLOC_XCNT_RST;
    end else if (wr_acc && paddr == `OFF_ALLOC) begin
      alloc_mask_reg <= pwdata[`ALLOC_MASK_MSB:0];
      extra_count_reg <= pwdata[`ALLOC_XCNT_MSB:`ALLOC_XCNT_LSB];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) object_id_reg <= 8'h00;
    else if (wr_acc && paddr == `OFF_OBJECT) object_id_reg <= pwdata[7:0];
  end

  // ---------------- target selection check ----------------
  // returns {br, bl, fr, fl} named by a default-framebuffer code
  function automatic logic [3:0] quad_of(input target_code_t c);
    case (c)
      `TGT_FL: quad_of = 4'h1;
      `TGT_FR: quad_of = 4'h2;
      `TGT_BL: quad_of = 4'h4;
      `TGT_BR: quad_of = 4'h8;
      `TGT_FRONT: quad_of = 4'h3;
      `TGT_BACK: quad_of = 4'hc;
      `TGT_LEFT: quad_of = 4'h5;
      `TGT_RIGHT: quad_of = 4'ha;
      `TGT_FAB: quad_of = 4'hf;
      default: quad_of = 4'h0;
    endcase
  endfunction

  target_code_t cmd;
  logic cmd_go, is_quad, is_extra, is_attach, bad_op, bad_val, bad_enum, cmd_ok;
  logic [3:0] cmd_n;
  assign cmd = pwdata[7:0];
  assign cmd_go = wr_acc && paddr == `OFF_TARGET;
  assign cmd_n = cmd[3:0];
  assign is_quad = quad_of(cmd) != 4'h0;
  assign is_extra = (cmd & `TGT_BASE_MASK) == `TGT_EXTRA0;
  assign is_attach = (cmd & `TGT_BASE_MASK) == `TGT_ATTACH0;

  always_comb begin
    bad_op = 1'b0;
    bad_val = 1'b0;
    bad_enum = 1'b0;
    if (cmd == `TGT_NONE) begin
      bad_op = 1'b0;
    end else if (object_id_reg == 8'h00) begin
      if (is_quad) bad_op = (quad_of(cmd) & alloc_mask_reg) == 4'h0;
      else if (is_extra) bad_op = {1'b0, cmd_n} >= extra_count_reg;
      else bad_enum = 1'b1;
    end else begin
      if (is_quad || is_extra) bad_op = 1'b1;
      else if (is_attach) bad_val = 32'(cmd_n) >= ATTACH_LIMIT;
      else bad_enum = 1'b1;
    end
  end
  assign cmd_ok = ~(bad_op | bad_val | bad_enum);

  // a rejected command leaves the selection as it was
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < COLORS; c++) target_reg[c] <= `TGT_NONE;
      target_reg[0] <= `TGT_BACK;
    end else if (wr_acc && paddr == `OFF_OBJECT) begin
      for (int c = 1; c < COLORS; c++) target_reg[c] <= `TGT_NONE;
      target_reg[0] <= (pwdata[7:0] != 8'h00) ? `TGT_ATTACH0 : `TGT_BACK;
    end else if (cmd_go && cmd_ok) begin
      for (int c = 1; c < COLORS; c++) target_reg[c] <= `TGT_NONE;
      target_reg[0] <= cmd;
    end
  end

  // error flags are sticky, write one to clear; a new error in the clearing cycle stays set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_reg <= 3'h0;
    end else begin
      err_reg <= (err_reg & ~((wr_acc && paddr == `OFF_STATUS) ? pwdata[2:0] : 3'h0)) |
                 ({bad_enum, bad_val, bad_op} & {3{cmd_go}});
    end
  end

  // ---------------- per-sample datapath ----------------
  logic rop_on, per_sample, take;
  logic [SAMPLES-1:0] run_mask, depth_next, sten_next;
  logic [COLORS-1:0][SAMPLES-1:0][3:0][CW-1:0] samp_next;
  logic [COLORS-1:0][SAMPLES-1:0] mask_next;
  logic [COLORS-1:0][3:0][CW-1:0] res_next;

  assign take = frag_valid & frag_ready;
  assign frag_ready = ~wr_valid | wr_ready;
  assign rop_on = (frag_index_mode ? index_en_reg : color_en_reg) & ~dest_float_reg;
  assign blend_active = blend_en_reg & ~color_en_reg;
  assign per_sample = msaa_en_reg && SAMPLE_BUFFERS == 1;

  always_comb begin
    if (target_reg[0] == `TGT_NONE) begin
      run_mask = '0;
      sten_next = '0;
      depth_next = '0;
    end else if (per_sample) begin
      run_mask = frag_coverage & frag_test_pass;
      sten_next = frag_coverage;
      depth_next = frag_coverage & frag_test_pass;
    end else begin
      run_mask = {SAMPLES{frag_center_pass}};
      sten_next = '1;
      depth_next = {SAMPLES{frag_center_pass}};
    end
  end

  genvar gc, gs, gk, gb;
  generate
    for (gc = 0; gc < COLORS; gc++) begin : g_col
      for (gk = 0; gk < 4; gk++) begin : g_comp
        logic [SW-1:0] sum;
        always_comb begin
          sum = '0;
          for (int s = 0; s < SAMPLES; s++) sum = sum + SW'(samp_next[gc][s][gk]);
        end
        // plain average; no linearisation is done for sRGB contents
        assign res_next[gc][gk] = CW'(sum >> $clog2(SAMPLES));
      end
      for (gs = 0; gs < SAMPLES; gs++) begin : g_smp
        assign mask_next[gc][gs] = run_mask[gs] & (target_reg[gc] != `TGT_NONE);
        for (gk = 0; gk < 4; gk++) begin : g_cmp
          for (gb = 0; gb < CW; gb++) begin : g_bit
            logic s_b, d_b, r_b;
            assign s_b = frag_src[gc][gk][gb];
            assign d_b = frag_dst[gc][gs][gk][gb];
            assign r_b = rop_on ? rop_reg[{~s_b, ~d_b}] : s_b;
            assign samp_next[gc][gs][gk][gb] = mask_next[gc][gs] ? r_b : d_b;
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_valid <= 1'b0;
    else if (frag_ready) wr_valid <= frag_valid;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_x <= 16'h0000;
      wr_y <= 16'h0000;
      wr_color_en <= '0;
      wr_target <= '0;
      wr_sample <= '0;
      wr_sample_mask <= '0;
      wr_depth_mask <= '0;
      wr_stencil_mask <= '0;
      wr_resolved <= '0;
    end else if (take) begin
      wr_x <= frag_x;
      wr_y <= frag_y;
      for (int c = 0; c < COLORS; c++) wr_color_en[c] <= target_reg[c] != `TGT_NONE;
      wr_target <= target_reg;
      wr_sample <= samp_next;
      wr_sample_mask <= mask_next;
      wr_depth_mask <= depth_next;
      wr_stencil_mask <= sten_next;
      wr_resolved <= res_next;
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_select_cmd;
    cmd_go && cmd_ok;
  endsequence
  sequence s_select_cmd_bad;
    cmd_go && !cmd_ok;
  endsequence

  property p_rop_copy_reset;
    $rose(presetn) |-> rop_reg == ROP_COPY && !index_en_reg && !color_en_reg;
  endproperty
  a_rop_copy_reset: assert property (p_rop_copy_reset) else $error("rop state not initial after reset");

  property p_blend_bypass;
    color_en_reg |-> !blend_active;
  endproperty
  a_blend_bypass: assert property (p_blend_bypass) else $error("blending active with colour rop");

  property p_float_no_rop;
    take && dest_float_reg && mask_next[0][0]
      |=> wr_sample[0][0][0] == $past(frag_src[0][0]);
  endproperty
  a_float_no_rop: assert property (p_float_no_rop) else $error("rop changed float destination");

  property p_xor_result;
    take && rop_on && rop_reg == ROP_XOR && mask_next[0][0]
      |=> wr_sample[0][0][0] == ($past(frag_src[0][0]) ^ $past(frag_dst[0][0][0]));
  endproperty
  a_xor_result: assert property (p_xor_result) else $error("xor result wrong");

  property p_none_no_write;
    take && target_reg[0] == `TGT_NONE |=> wr_sample_mask[0] == '0 && wr_depth_mask == '0 && !wr_color_en[0];
  endproperty
  a_none_no_write: assert property (p_none_no_write) else $error("write with target none");

  property p_uncovered_kept;
    take && per_sample && !frag_coverage[SAMPLES/2]
      |=> wr_sample[0][SAMPLES/2] == $past(frag_dst[0][SAMPLES/2]);
  endproperty
  a_uncovered_kept: assert property (p_uncovered_kept) else $error("uncovered sample modified");

  property p_center_fail;
    take && !per_sample && !frag_center_pass && target_reg[0] != `TGT_NONE
      |=> wr_depth_mask == '0 && wr_sample_mask == '0 && wr_stencil_mask == '1;
  endproperty
  a_center_fail: assert property (p_center_fail) else $error("centre fail changed samples");

  property p_single_target;
    s_select_cmd |=> target_reg[0] == $past(cmd) && (COLORS < 2 || target_reg[COLORS-1] == `TGT_NONE);
  endproperty
  a_single_target: assert property (p_single_target) else $error("target select not applied");

  property p_bad_kept;
    s_select_cmd_bad |=> $stable(target_reg) ##0 err_reg != 3'h0;
  endproperty
  a_bad_kept: assert property (p_bad_kept) else $error("bad selector changed target or no error");

  property p_object_default_code;
    cmd_go && object_id_reg != 8'h00 && is_quad |=> err_reg[`ST_BAD_OP];
  endproperty
  a_object_default_code: assert property (p_object_default_code) else $error("no bad operation error");

  property p_out_held;
    wr_valid && !wr_ready |=> wr_valid && $stable(wr_sample) && $stable(wr_x);
  endproperty
  a_out_held: assert property (p_out_held) else $error("write bundle dropped under stall");
endmodule
`default_nettype wire

//--- bench/fb_mem_model.sv
// downstream framebuffer memory model: takes write bundles, promptly or slowly
// assumes: one pclk domain, wr_valid held by the stage until accepted
`timescale 1ns/100ps
`default_nettype none
module fb_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic wr_valid,
  output logic wr_ready,
  output int n_wr
);
  logic [1:0] cnt_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cnt_reg <= 2'h0;
    else
      cnt_reg <= cnt_reg + 2'h1;
  end
  // slow mode accepts once in four cycles, so the stage must hold its bundle
  assign wr_ready = !slow || (cnt_reg == 2'h3);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      n_wr <= 0;
    else if (wr_valid && wr_ready)
      n_wr <= n_wr + 1;
  end
endmodule
`default_nettype wire

//--- bench/tb.sv
// testbench of the raster-op stage: APB register tasks, fragment task, checks
// assumes: rop_cfg.svh on the include path, default stage parameters
`timescale 1ns/100ps
`default_nettype none
`include "rop_cfg.svh"
module tb;
  logic pclk, presetn = 0, psel = 0, penable = 0, pwrite = 0, slow = 0;
  logic frag_valid = 0, frag_index_mode = 0, frag_center_pass = 0, ev;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rv;
  logic pready, pslverr, frag_ready, wr_valid, wr_ready, blend_active;
  logic [15:0] frag_x = 16'h0012, frag_y = 16'h0034, wr_x, wr_y;
  logic [1:0][3:0][7:0] frag_src = '0, wr_resolved;
  logic [1:0][3:0][3:0][7:0] frag_dst = '0, wr_sample;
  logic [3:0] frag_coverage = '0, frag_test_pass = '0, wr_depth_mask, wr_stencil_mask;
  logic [1:0] wr_color_en;
  logic [1:0][3:0] wr_sample_mask;
  rop_pkg::target_code_t [1:0] wr_target;
  int failures = 0, n_tests = 0, cyc = 0, n_wr;
  localparam logic [31:0] S = 32'h0ff0cc33, D = 32'h55aaaa55;
  localparam logic [3:0][31:0] DS = {32'h0c0c0c0c, 32'h08080808, 32'h04040404, 32'h0};

  fragment_rop uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .frag_valid, .frag_ready, .frag_index_mode, .frag_x, .frag_y, .frag_src, .frag_dst,
    .frag_coverage, .frag_test_pass, .frag_center_pass, .wr_valid, .wr_ready, .wr_x, .wr_y,
    .wr_color_en, .wr_target, .wr_sample, .wr_sample_mask, .wr_depth_mask, .wr_stencil_mask,
    .wr_resolved, .blend_active);
  fb_mem_model mem (.pclk, .presetn, .slow, .wr_valid, .wr_ready, .n_wr);

  initial begin
    pclk = 0;
    forever #25 pclk = ~pclk;
  end

  task end_sim;
    $display("checks %0d mismatches %0d writes %0d", n_tests, failures, n_wr);
    if (failures == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc++;
    if (cyc > 5000) begin
      failures++;
      end_sim();
    end
  end

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rv, e);
  endtask

  // bad selector: status bit expected, then cleared by writing ones
  task terr(input logic [7:0] code, input logic [31:0] e);
    apb(1'b1, `OFF_TARGET, 32'(code));
    rdc("status", `OFF_STATUS, e);
    apb(1'b1, `OFF_STATUS, 32'h7);
  endtask

  task ctl(input logic [3:0] op, input logic [4:0] b);
    apb(1'b1, `OFF_CTRL, {20'h0, op, 3'h0, b});
    @(posedge pclk);
  endtask

  task frag(input logic [31:0] s, input logic [3:0][31:0] d, input logic [3:0] cv, ps, input logic cp, im);
    @(posedge pclk);
    frag_valid <= 1'b1;
    frag_src <= {~s, s};
    frag_dst <= {d, d};
    frag_coverage <= cv;
    frag_test_pass <= ps;
    frag_center_pass <= cp;
    frag_index_mode <= im;
    do @(posedge pclk); while (frag_ready !== 1'b1);
    frag_valid <= 1'b0;
    do @(posedge pclk); while ((wr_valid & wr_ready) !== 1'b1);
  endtask

  // expected results written from the function list, not from the truth-table trick
  function automatic logic [31:0] rop_ref(input logic [3:0] op, input logic [31:0] s, d);
    logic [31:0] r;
    case (op)
      4'h0: r = 32'h0000_0000;
      4'h1: r = s & d;
      4'h2: r = s & ~d;
      4'h3: r = s;
      4'h4: r = ~s & d;
      4'h5: r = d;
      4'h6: r = s ^ d;
      4'h7: r = s | d;
      4'h8: r = ~(s | d);
      4'h9: r = ~(s ^ d);
      4'ha: r = ~d;
      4'hb: r = s | ~d;
      4'hc: r = ~s;
      4'hd: r = ~s | d;
      4'he: r = ~(s & d);
      default: r = 32'hffff_ffff;
    endcase
    return r;
  endfunction

  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdc("ctrl", `OFF_CTRL, 32'h300);
    rdc("target", `OFF_TARGET, 32'h06);
    rdc("object", `OFF_OBJECT, 32'h0);
    rdc("alloc", `OFF_ALLOC, 32'h00f);
    rdc("status", `OFF_STATUS, 32'h0);
    chk("blend", 32'(blend_active), 32'h0);
    apb(1'b0, 12'h014, 32'h0);
    chk("unmapped", rv, 32'h0);
    chk("slverr", 32'(ev), 32'h1);
    $display("test reset done");
    for (int k = 0; k < 16; k++) begin
      ctl(4'(k), 5'h0a);
      frag(S, {4{D}}, 4'hf, 4'hf, 1'b0, 1'b0);
      chk("rop", wr_sample[0][2], rop_ref(4'(k), S, D));
      chk("resolve", wr_resolved[0], rop_ref(4'(k), S, D));
    end
    chk("c1 target", 32'(wr_target[1]), 32'h0);
    chk("c1 mask", 32'(wr_sample_mask[1]), 32'h0);
    chk("c1 keep", wr_sample[1][0], D);
    chk("xy", {wr_x, wr_y}, 32'h00120034);
    chk("c0 target", 32'(wr_target[0]), 32'h06);
    chk("colour en", 32'(wr_color_en), 32'h1);
    $display("test functions done");
    ctl(4'h6, 5'h0a);
    slow <= 1'b1;
    frag(32'h10101010, DS, 4'b1011, 4'b1101, 1'b0, 1'b0);
    slow <= 1'b0;
    chk("smask", 32'(wr_sample_mask[0]), 32'h9);
    chk("dmask", 32'(wr_depth_mask), 32'h9);
    chk("stmask", 32'(wr_stencil_mask), 32'hb);
    chk("s1", wr_sample[0][1], 32'h04040404);
    chk("s2", wr_sample[0][2], 32'h08080808);
    chk("s3", wr_sample[0][3], 32'h1c1c1c1c);
    chk("avg", wr_resolved[0], 32'h0e0e0e0e);
    ctl(4'h6, 5'h02);
    frag(32'h10101010, DS, 4'b0001, 4'b0000, 1'b1, 1'b0);
    chk("smask", 32'(wr_sample_mask[0]), 32'hf);
    chk("dmask", 32'(wr_depth_mask), 32'hf);
    chk("s2", wr_sample[0][2], 32'h18181818);
    chk("avg", wr_resolved[0], 32'h16161616);
    frag(32'h10101010, DS, 4'b1111, 4'b1111, 1'b0, 1'b0);
    chk("smask", 32'(wr_sample_mask[0]), 32'h0);
    chk("dmask", 32'(wr_depth_mask), 32'h0);
    chk("stmask", 32'(wr_stencil_mask), 32'hf);
    $display("test samples done");
    ctl(4'h3, 5'h04);
    chk("blend", 32'(blend_active), 32'h1);
    ctl(4'h3, 5'h06);
    chk("blend", 32'(blend_active), 32'h0);
    ctl(4'h6, 5'h1e);
    frag(S, {4{D}}, 4'hf, 4'hf, 1'b0, 1'b0);
    chk("float", wr_sample[0][0], S);
    chk("blend", 32'(blend_active), 32'h0);
    ctl(4'h6, 5'h09);
    frag(S, {4{D}}, 4'hf, 4'hf, 1'b0, 1'b1);
    chk("index", wr_sample[0][0], S ^ D);
    frag(S, {4{D}}, 4'hf, 4'hf, 1'b0, 1'b0);
    chk("colour off", wr_sample[0][0], S);
    $display("test enables done");
    apb(1'b1, `OFF_TARGET, 32'h0);
    frag(S, {4{D}}, 4'hf, 4'hf, 1'b0, 1'b0);
    chk("none", {wr_sample_mask, wr_depth_mask, wr_stencil_mask}, 32'h0);
    chk("none en", 32'(wr_color_en), 32'h0);
    for (int k = 1; k < 10; k++) begin
      apb(1'b1, `OFF_TARGET, 32'(k));
      rdc("target", `OFF_TARGET, 32'(k));
    end
    apb(1'b1, `OFF_ALLOC, 32'h0201);
    terr(`TGT_FR, 32'h1);
    rdc("target", `OFF_TARGET, 32'h09);
    apb(1'b1, `OFF_TARGET, 32'h11);
    rdc("extra", `OFF_TARGET, 32'h11);
    terr(8'h12, 32'h1);
    terr(8'h0a, 32'h4);
    apb(1'b1, `OFF_OBJECT, 32'h1);
    rdc("attach0", `OFF_TARGET, 32'h20);
    terr(`TGT_BACK, 32'h1);
    terr(8'h24, 32'h2);
    apb(1'b1, `OFF_TARGET, 32'h23);
    rdc("attach3", `OFF_TARGET, 32'h23);
    apb(1'b1, `OFF_OBJECT, 32'h0);
    rdc("back", `OFF_TARGET, 32'h06);
    $display("test targets done");
    end_sim();
  end
endmodule
`default_nettype wire
